// ===== count_decoder.sv
`timescale 1ns/1ps
`include "encoder_pulser_map.svh"

module count_decoder
    import encoder_pulser_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      rst_n_i,
    input  wire logic      a_i,
    input  wire logic      b_i,
    input  wire chan_cfg_t cfg_i,
    output count_evt_t     evt_o
);

    logic       a_prev_ff;
    logic       b_prev_ff;
    count_evt_t evt_ff;
    count_evt_t nxt_evt;
    logic       a_edge;
    logic       b_edge;
    logic       cnt;
    logic       fwd;

    // ======================================================================
    // edge classification and count direction
    // ======================================================================
    always_comb begin
        a_edge = a_i ^ a_prev_ff;
        b_edge = b_i ^ b_prev_ff;
        cnt    = 1'b0;
        fwd    = 1'b0;
        case (cfg_i.mode)
            QUAD_1X: begin
                // one count per cycle, at the a edge taken with b low
                cnt = a_edge && !b_edge && !b_i;
                fwd = a_i;
            end
            QUAD_2X: begin
                cnt = a_edge && !b_edge;
                fwd = a_i != b_i;
            end
            QUAD_4X: begin
                cnt = a_edge ^ b_edge;
                fwd = a_edge ? (a_i != b_i) : (a_i == b_i);
            end
            TWO_PULSE: begin
                // simultaneous edges on a and b give no count and are flagged as an error
                cnt = (a_edge ^ b_edge) && (a_edge ? a_i : !b_i);
                fwd = a_i && !a_prev_ff;
            end
            default: begin
                cnt = 1'b0;
                fwd = 1'b0;
            end
        endcase
        nxt_evt.up  = !cfg_i.dis && cnt && (fwd ^ cfg_i.dir);
        nxt_evt.dn  = !cfg_i.dis && cnt && !(fwd ^ cfg_i.dir);
        nxt_evt.err = !cfg_i.dis && a_edge && b_edge;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            a_prev_ff <= 1'b0;
            b_prev_ff <= 1'b0;
            evt_ff    <= '0;
        end else begin
            a_prev_ff <= a_i;
            b_prev_ff <= b_i;
            evt_ff    <= nxt_evt;
        end
    end

    assign evt_o = evt_ff;

    // ======================================================================
    // checks
    // ======================================================================
    chk_both_edges_err: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!cfg_i.dis && (a_i != a_prev_ff) && (b_i != b_prev_ff))
        |=> evt_ff.err && !evt_ff.up && !evt_ff.dn)
        else $error("simultaneous a and b change not flagged");

    chk_quad_4x_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_i.mode == QUAD_4X && !cfg_i.dis && ((a_i != a_prev_ff) ^ (b_i != b_prev_ff)))
        |=> (evt_ff.up ^ evt_ff.dn))
        else $error("4x edge produced no single count");

    chk_quad_1x_skip: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_i.mode == QUAD_1X && b_i && b_prev_ff)
        |=> !evt_ff.up && !evt_ff.dn)
        else $error("1x counted with b high");

    chk_two_pulse_up: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_i.mode == TWO_PULSE && !cfg_i.dis && !cfg_i.dir && a_i && !a_prev_ff
         && b_i == b_prev_ff)
        |=> evt_ff.up && !evt_ff.dn)
        else $error("two-pulse a rise did not count up");

    chk_dir_reverse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_i.mode == QUAD_2X && !cfg_i.dis && cfg_i.dir && a_i && !a_prev_ff
         && !b_i && !b_prev_ff)
        |=> evt_ff.dn && !evt_ff.up)
        else $error("reversed direction did not count down");

    chk_disable_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg_i.dis |=> !evt_ff.up && !evt_ff.dn && !evt_ff.err)
        else $error("disabled input still counted");

    cov_two_pulse_down: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg_i.mode == TWO_PULSE ##1 evt_ff.dn);

endmodule

// ===== encoder_pulser_input_decoder.sv
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "encoder_pulser_map.svh"

module encoder_pulser_input_decoder
    import encoder_pulser_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    input  wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [`ADDR_W-1:0] s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               encoder_phase_a_i,
    input  wire logic               encoder_phase_b_i,
    input  wire logic               encoder_index_i,
    input  wire logic               manual_pulser_a_i,
    input  wire logic               manual_pulser_b_i,
    output logic                    enc_count_up_o,
    output logic                    enc_count_down_o,
    output logic                    pulser_count_up_o,
    output logic                    pulser_count_down_o,
    output logic                    encoder_index_o,
    output logic                    irq_o
);

    localparam int NUM_PINS = 5;

    // ======================================================================
    // state
    // ======================================================================
    logic [NUM_PINS-1:0] sync1_ff;
    logic [NUM_PINS-1:0] sync2_ff;
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] filt_en;
    logic [NUM_PINS-1:0] filt_out;
    chan_cfg_t           enc_cfg;
    chan_cfg_t           pls_cfg;
    count_evt_t          enc_evt;
    count_evt_t          pls_evt;

    logic               awready_ff;
    logic               nxt_awready;
    logic               wready_ff;
    logic               nxt_wready;
    logic               bvalid_ff;
    logic               nxt_bvalid;
    logic [1:0]         bresp_ff;
    logic [1:0]         nxt_bresp;
    logic [`ADDR_W-1:0] awaddr_ff;
    logic [`ADDR_W-1:0] nxt_awaddr;
    logic [31:0]        wdata_ff;
    logic [31:0]        nxt_wdata;
    logic [3:0]         wstrb_ff;
    logic [3:0]         nxt_wstrb;
    logic               arready_ff;
    logic               nxt_arready;
    logic               rvalid_ff;
    logic               nxt_rvalid;
    logic [31:0]        rdata_ff;
    logic [31:0]        nxt_rdata;
    logic [1:0]         rresp_ff;
    logic [1:0]         nxt_rresp;

    logic [31:0]        cfg_ff;
    logic [31:0]        nxt_cfg;
    logic [1:0]         status_ff;
    logic [1:0]         nxt_status;
    logic [1:0]         mask_ff;
    logic [1:0]         nxt_mask;
    logic               irq_ff;
    logic               nxt_irq;
    logic               do_wr;
    logic [`ADDR_W-1:0] wr_word;
    logic [`ADDR_W-1:0] rd_word;
    logic [1:0]         clr;

    // ======================================================================
    // input synchroniser and pulse-width filters
    // ======================================================================
    // bit order: encoder a, b, index, pulser a, b
    assign pin_raw = {manual_pulser_b_i, manual_pulser_a_i, encoder_index_i,
                      encoder_phase_b_i, encoder_phase_a_i};
    assign filt_en = {cfg_ff[`PFLT_BIT], cfg_ff[`PFLT_BIT], cfg_ff[`EFLT_BIT],
                      cfg_ff[`EFLT_BIT], cfg_ff[`EFLT_BIT]};

    // two flops per pin; only the second stage feeds the filter
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_filt
        pulse_width_filter u_filt (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .en_i      (filt_en[i]),
            .in_i      (sync2_ff[i]),
            .out_o     (filt_out[i])
        );
    end

    // ======================================================================
    // decoders
    // ======================================================================
    // index bypasses the decoder, so the encoder disable never blocks it
    assign enc_cfg = '{filt: cfg_ff[`EFLT_BIT],
                       mode: count_mode_t'(cfg_ff[`EMD_MSB:`EMD_LSB]),
                       dir:  cfg_ff[`ERVS_BIT],
                       dis:  cfg_ff[`EDIS_BIT]};
    assign pls_cfg = '{filt: cfg_ff[`PFLT_BIT],
                       mode: count_mode_t'(cfg_ff[`PMD_MSB:`PMD_LSB]),
                       dir:  cfg_ff[`PRVS_BIT],
                       dis:  cfg_ff[`PDIS_BIT]};

    count_decoder u_enc_dec (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .a_i       (filt_out[0]),
        .b_i       (filt_out[1]),
        .cfg_i     (enc_cfg),
        .evt_o     (enc_evt)
    );

    count_decoder u_pls_dec (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .a_i       (filt_out[3]),
        .b_i       (filt_out[4]),
        .cfg_i     (pls_cfg),
        .evt_o     (pls_evt)
    );

    // ======================================================================
    // axi4-lite slave: handshakes
    // ======================================================================
    // one write and one read in flight; readies drop until the response leaves
    always_comb begin
        nxt_awready = awready_ff;
        nxt_wready  = wready_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        do_wr       = !awready_ff && !wready_ff && !bvalid_ff;
        wr_word     = {awaddr_ff[`ADDR_W-1:2], 2'h0};
        if (s_axi_awvalid && awready_ff) begin
            nxt_awready = 1'b0;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_wready = 1'b0;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = (wr_word == `OFS_INPUT_ENV_CFG || wr_word == `OFS_ERR_CAUSE
                          || wr_word == `OFS_ERR_MASK) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid  = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready  = 1'b1;
        end
    end

    // read data is captured at the address handshake
    always_comb begin
        nxt_arready = arready_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        rd_word     = {s_axi_araddr[`ADDR_W-1:2], 2'h0};
        if (s_axi_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid  = 1'b1;
            nxt_rdata   = 32'h0000_0000;
            nxt_rresp   = `RESP_OKAY;
            case (rd_word)
                // configuration is write-only and reads as zero
                `OFS_INPUT_ENV_CFG: nxt_rdata = 32'h0000_0000;
                `OFS_ERR_CAUSE: begin
                    nxt_rdata[`ENC_ERR_BIT] = status_ff[0];
                    nxt_rdata[`PLS_ERR_BIT] = status_ff[1];
                end
                `OFS_ERR_MASK: begin
                    nxt_rdata[`ENC_ERR_BIT] = mask_ff[0];
                    nxt_rdata[`PLS_ERR_BIT] = mask_ff[1];
                end
                default: nxt_rresp = `RESP_SLVERR;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid  = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    // ======================================================================
    // registers, sticky error flags and interrupt
    // ======================================================================
    // set beats clear, so an error in the clearing cycle survives
    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_mask = mask_ff;
        clr      = 2'h0;
        if (do_wr) begin
            if (wr_word == `OFS_INPUT_ENV_CFG) begin
                for (int k = 0; k < 4; k++) begin
                    if (wstrb_ff[k]) begin
                        nxt_cfg[k*8 +: 8] = wdata_ff[k*8 +: 8];
                    end
                end
            end
            if (wr_word == `OFS_ERR_CAUSE && wstrb_ff[2]) begin
                clr = {wdata_ff[`PLS_ERR_BIT], wdata_ff[`ENC_ERR_BIT]};
            end
            if (wr_word == `OFS_ERR_MASK && wstrb_ff[2]) begin
                nxt_mask = {wdata_ff[`PLS_ERR_BIT], wdata_ff[`ENC_ERR_BIT]};
            end
        end
        nxt_status = (status_ff & ~clr) | {pls_evt.err, enc_evt.err};
        nxt_irq    = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `RESP_OKAY;
            cfg_ff     <= `CFG_RESET;
            status_ff  <= 2'h0;
            mask_ff    <= `MASK_RESET;
            irq_ff     <= 1'b0;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            cfg_ff     <= nxt_cfg;
            status_ff  <= nxt_status;
            mask_ff    <= nxt_mask;
            irq_ff     <= nxt_irq;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign s_axi_awready       = awready_ff;
    assign s_axi_wready        = wready_ff;
    assign s_axi_bvalid        = bvalid_ff;
    assign s_axi_bresp         = bresp_ff;
    assign s_axi_arready       = arready_ff;
    assign s_axi_rvalid        = rvalid_ff;
    assign s_axi_rdata         = rdata_ff;
    assign s_axi_rresp         = rresp_ff;
    assign enc_count_up_o      = enc_evt.up;
    assign enc_count_down_o    = enc_evt.dn;
    assign pulser_count_up_o   = pls_evt.up;
    assign pulser_count_down_o = pls_evt.dn;
    assign encoder_index_o     = filt_out[2];
    assign irq_o               = irq_ff;

    // ======================================================================
    // checks
    // ======================================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_enc_err_sticky: assert property (enc_evt.err |=> status_ff[0])
        else $error("encoder phase error not latched");

    chk_pls_err_sticky: assert property (pls_evt.err |=> status_ff[1])
        else $error("pulser phase error not latched");

    chk_err_holds: assert property ((status_ff[0] && clr[0] == 1'b0) |=> status_ff[0])
        else $error("encoder phase error lost without clear");

    chk_irq_level: assert property (irq_o == |(status_ff & mask_ff))
        else $error("interrupt does not match masked status");

    chk_index_path: assert property ((!cfg_ff[`EFLT_BIT])[*4] |->
        encoder_index_o == $past(encoder_index_i, 3))
        else $error("index path latency wrong");

    chk_enc_off_quiet: assert property (cfg_ff[`EDIS_BIT] |=>
        !enc_count_up_o && !enc_count_down_o)
        else $error("encoder counted while disabled");

    cov_enc_count: cover property (enc_count_up_o ##[1:20] enc_count_down_o);
    cov_irq_raise: cover property (!irq_o ##1 irq_o);
    cov_wr_then_rd: cover property (bvalid_ff ##[1:10] rvalid_ff);

endmodule

// ===== encoder_pulser_map.svh
`ifndef ENCODER_PULSER_MAP_SVH
`define ENCODER_PULSER_MAP_SVH

// ==========================================================================
// register map
// ==========================================================================
`define ADDR_W              8
`define OFS_INPUT_ENV_CFG   8'h00
`define OFS_ERR_CAUSE       8'h04
`define OFS_ERR_MASK        8'h08

// ==========================================================================
// input_environment_config fields
// ==========================================================================
`define EFLT_BIT            18
`define PFLT_BIT            19
`define EMD_LSB             20
`define EMD_MSB             21
`define ERVS_BIT            22
`define PMD_LSB             24
`define PMD_MSB             25
`define PRVS_BIT            26
`define EDIS_BIT            30
`define PDIS_BIT            31

// ==========================================================================
// error_cause_status and mask fields
// ==========================================================================
`define ENC_ERR_BIT         16
`define PLS_ERR_BIT         17

// ==========================================================================
// reset values and timing
// ==========================================================================
`define CFG_RESET           32'h0000_0000
`define MASK_RESET          2'h0
`define FILT_MIN_CYCLES     3
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== encoder_pulser_pkg.sv
package encoder_pulser_pkg;

    // decoding selected by the two-bit count mode field
    typedef enum logic [1:0] {
        QUAD_1X,
        QUAD_2X,
        QUAD_4X,
        TWO_PULSE
    } count_mode_t;

    // per-channel settings taken from input_environment_config
    typedef struct packed {
        logic        filt;
        count_mode_t mode;
        logic        dir;
        logic        dis;
    } chan_cfg_t;

    // one-cycle strobes produced by a decoder
    typedef struct packed {
        logic up;
        logic dn;
        logic err;
    } count_evt_t;

endpackage

// ===== pulse_width_filter.sv
`timescale 1ns/1ps
`include "encoder_pulser_map.svh"

module pulse_width_filter (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic en_i,
    input  wire logic in_i,
    output logic      out_o
);

    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic       out_ff;
    logic       nxt_out;

    // ======================================================================
    // level accepted only after it held for the minimum width
    // ======================================================================
    always_comb begin
        nxt_cnt = 2'h0;
        nxt_out = out_ff;
        if (!en_i) begin
            nxt_out = in_i;
        end else if (in_i != out_ff) begin
            if (cnt_ff == 2'(`FILT_MIN_CYCLES - 1)) begin
                nxt_out = in_i;
            end else begin
                nxt_cnt = cnt_ff + 2'h1; // a shorter pulse restarts the count
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 2'h0;
            out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign out_o = out_ff;

    // ======================================================================
    // checks
    // ======================================================================
    chk_filter_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (en_i && $past(en_i) && $past(en_i, 2) && $past(en_i, 3) && $changed(out_ff))
        |-> ($past(in_i) == out_ff && $past(in_i, 2) == out_ff && $past(in_i, 3) == out_ff))
        else $error("filtered level changed before minimum width");

endmodule

// ===== quad_source.sv
`timescale 1ns/1ps
// ==========================================
// encoder / pulser source: each request flips the selected line or both lines
// ==========================================
module quad_source (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic tog_a_i,
    input  wire logic tog_b_i,
    output logic      a_o,
    output logic      b_o
);
    // push-pull lines keep their level between steps
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            a_o <= 1'b0;
            b_o <= 1'b0;
        end else begin
            a_o <= a_o ^ tog_a_i;
            b_o <= b_o ^ tog_b_i;
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "encoder_pulser_map.svh"
module tb;
    logic        clk_sys_i = 0, rst_n_i = 0, ta = 0, tb2 = 0, clr = 0, encoder_index_i = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        encoder_phase_a_i, encoder_phase_b_i, manual_pulser_a_i, manual_pulser_b_i;
    logic        enc_count_up_o, enc_count_down_o, pulser_count_up_o, pulser_count_down_o;
    logic        encoder_index_o, irq_o;
    int          n_fail = 0, tests_run = 0, f, r;
    integer      eu, ed, pu, pd;
    quad_source enc (.clk_sys_i, .rst_n_i, .tog_a_i(ta), .tog_b_i(tb2),
                     .a_o(encoder_phase_a_i), .b_o(encoder_phase_b_i));
    quad_source pls (.clk_sys_i, .rst_n_i, .tog_a_i(ta), .tog_b_i(tb2),
                     .a_o(manual_pulser_a_i), .b_o(manual_pulser_b_i));
    encoder_pulser_input_decoder dut (.clk_sys_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encoder_phase_a_i,
        .encoder_phase_b_i, .encoder_index_i, .manual_pulser_a_i, .manual_pulser_b_i,
        .enc_count_up_o, .enc_count_down_o, .pulser_count_up_o, .pulser_count_down_o,
        .encoder_index_o, .irq_o);
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    // strobe tallies, cleared only while the lines are quiet
    always @(posedge clk_sys_i) begin
        eu <= clr ? 0 : eu + enc_count_up_o;
        ed <= clr ? 0 : ed + enc_count_down_o;
        pu <= clr ? 0 : pu + pulser_count_up_o;
        pd <= clr ? 0 : pd + pulser_count_down_o;
    end
    // ==========================================
    // checks and bus cycles
    // ==========================================
    task automatic complete_run();
        $display("tests %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // readies are registered, so the value seen at the falling edge is the one sampled next
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        @(posedge clk_sys_i);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys_i);
            {ha, hw, hb} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
                            s_axi_bvalid & s_axi_bready};
            if (hb) rsp = s_axi_bresp;
            @(posedge clk_sys_i);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            if (hb) return;
        end
        n_fail++;
        complete_run();
    endtask
    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        @(posedge clk_sys_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys_i);
            {ha, hr} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
            if (hr) {rd_v, rsp} = {s_axi_rdata, s_axi_rresp};
            @(posedge clk_sys_i);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
            if (hr) return;
        end
        n_fail++;
        complete_run();
    endtask
    // one request flips the selected line or lines, then w quiet cycles before returning
    task automatic tg(input logic x, input logic y, input int w);
        @(posedge clk_sys_i) {ta, tb2} <= {x, y};
        @(posedge clk_sys_i) {ta, tb2} <= 2'h0;
        repeat (w) @(posedge clk_sys_i);
    endtask
    // forward: a leads (a,b,a,b); two-pulse: one pulse on a or on b
    task automatic cyc(input logic fwd, input logic two);
        for (int k = 0; k < (two ? 2 : 4); k++) tg(two ? fwd : fwd ^ k[0], two ? !fwd : !(fwd ^ k[0]), 6);
    endtask
    function automatic logic [31:0] cfg(int m, int d, int fl, int ds);
        return (fl * 32'h000c_0000) | (m * 32'h0110_0000) | (d * 32'h0440_0000) | (ds * 32'hc000_0000);
    endfunction
    function automatic logic [31:0] ex(int m, int n);
        return m == 3 ? n : n * (m == 0 ? 1 : m == 1 ? 2 : 4);
    endfunction
    task automatic counts(input logic [31:0] u, input logic [31:0] dn);
        repeat (10) @(posedge clk_sys_i);
        chk(eu, u); chk(ed, dn); chk(pu, u); chk(pd, dn);
        @(posedge clk_sys_i) clr <= 1'b1;
        @(posedge clk_sys_i) clr <= 1'b0;
    endtask
    // ==========================================
    // scenarios
    // ==========================================
    initial begin
        void'($urandom(32'ha60860a8));
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        clr <= 1'b1;
        @(posedge clk_sys_i) clr <= 1'b0;
        rd(`OFS_INPUT_ENV_CFG); chk(rd_v, 32'h0); chk(rsp, `RESP_OKAY);
        rd(8'h0c); chk(rsp, `RESP_SLVERR); wr(8'h0c, 32'h0); chk(rsp, `RESP_SLVERR); // unmapped
        for (int m = 0; m < 4; m++) for (int d = 0; d < 2; d++) begin
            wr(`OFS_INPUT_ENV_CFG, cfg(m, d, 0, 0));
            f = $urandom_range(3, 1);
            r = $urandom_range(2, 0);
            repeat (f) cyc(1'b1, m == 3);
            repeat (r) cyc(1'b0, m == 3);
            counts(ex(m, d ? r : f), ex(m, d ? f : r));
            $display("mode %0d dir %0d done", m, d);
        end
        // 2-cycle glitch dropped by the filter, a clean cycle still counts
        wr(`OFS_INPUT_ENV_CFG, cfg(2, 0, 1, 0));
        tg(1'b1, 1'b0, 0); tg(1'b1, 1'b0, 8);
        counts(0, 0);
        cyc(1'b1, 1'b0);
        counts(4, 0);
        $display("filter done");
        // both lines at once: error, no count; irq only once masked; write one clears
        tg(1'b1, 1'b1, 8); tg(1'b1, 1'b1, 8);
        counts(0, 0);
        chk(irq_o, 1'b0);
        rd(`OFS_ERR_CAUSE); chk(rd_v, 32'h0003_0000);
        wr(`OFS_ERR_MASK, 32'h0003_0000); chk(rsp, `RESP_OKAY);
        @(negedge clk_sys_i) chk(irq_o, 1'b1);
        wr(`OFS_ERR_CAUSE, 32'h0003_0000);
        rd(`OFS_ERR_CAUSE); chk(rd_v, 32'h0); chk(irq_o, 1'b0);
        $display("error flags done");
        // disabled channels ignore steps and errors, index still passes
        wr(`OFS_INPUT_ENV_CFG, cfg(2, 0, 0, 1));
        encoder_index_i <= 1'b1;
        cyc(1'b1, 1'b0); tg(1'b1, 1'b1, 8);
        counts(0, 0);
        chk(encoder_index_o, 1'b1);
        rd(`OFS_ERR_CAUSE); chk(rd_v, 32'h0);
        $display("disable done");
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_fail++;
        complete_run();
    end
endmodule
